/* src/serial_pkg.sv */
// Constants and types shared by the serial port block
package serial_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int NPORT = 3;
  localparam int SAMPLE_MS = 20;
  localparam int SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
  localparam int SPAN_MS = 8000;
  localparam int BUF_LINES = SPAN_MS / SAMPLE_MS;
  localparam int HDR_LEN = 11;
  localparam int LINE_LEN = 8;
  localparam int END_LEN = 3;
  localparam logic [9:0] MAX_READING = 10'h3E7;
  localparam logic [9:0] MAX_SEQ = 10'h3E7;
  // Register byte offsets
  localparam logic [7:0] OFF_CFG0 = 8'h00;
  localparam logic [7:0] OFF_ACT0 = 8'h0C;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam logic [7:0] OFF_ALARM = 8'h20;
  localparam logic [7:0] OFF_TXD0 = 8'h24;
  localparam logic [7:0] OFF_RXD0 = 8'h30;
  localparam logic [7:0] PORT_STEP = 8'h04;
  // Config, command, status and alarm field layout
  localparam int F_DEV = 0;
  localparam int F_BAUD = 2;
  localparam int F_BITS8 = 5;
  localparam int F_PAR = 6;
  localparam int CMD_CANCEL = 3;
  localparam int ST_RXV = 3;
  localparam int ST_REJ = 6;
  localparam int AL_ACTIVE = 0;
  localparam int AL_SILENCE = 1;
  localparam logic [1:0] DEV_MONITOR = 2'h0;
  localparam logic [1:0] DEV_WAVE = 2'h3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [2:0] BAUD_MAX = 3'h5;
  localparam logic [2:0] BAUD_38400 = 3'h5;
  // 9600, eight bits, no parity, monitor protocol
  localparam logic [7:0] CFG_RESET = 8'h2C;
  localparam int BAUD_RATE [6] = '{1200, 2400, 4800, 9600, 19200, 38400};

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HDR = 4'b0010,
    ST_LINE = 4'b0100,
    ST_END = 4'b1000
  } wave_state_t;

  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int idx;
    idx = (sel > BAUD_MAX) ? 5 : int'(sel);
    return 16'(CLK_HZ / BAUD_RATE[idx]);
  endfunction
endpackage

/* src/serial_port_waveform_streamer.sv */
// Serial ports, waveform streamer and remote alarm relay
`timescale 1ns/100ps
module uart_port
  import serial_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] div,
  input wire logic bits8,
  input wire logic [1:0] par,
  input wire logic tx_go,
  input wire logic [7:0] tx_byte,
  output logic tx_rdy,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_take,
  output logic txd,
  input wire logic rxd,
  output logic rts,
  input wire logic cts,
  output logic dtr
);
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_left_reg;
  logic [15:0] tx_cnt_reg;
  logic [9:0] rx_sh_reg;
  logic [3:0] rx_left_reg;
  logic [15:0] rx_cnt_reg;
  logic rx_busy_reg;
  logic p_bit;
  logic [3:0] nbits;

  always_comb begin
    p_bit = (par == PAR_ODD) ? ~^tx_byte[6:0] : ^tx_byte[6:0];
    nbits = (bits8 || par != PAR_NONE) ? 4'hA : 4'h9;
  end

  assign tx_rdy = (tx_left_reg == 4'h0) && cts;

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_sh_reg <= 11'h7FF;
      tx_left_reg <= 4'h0;
      tx_cnt_reg <= 16'h0000;
      txd <= 1'b1;
    end else if (tx_go && tx_rdy) begin
      if (bits8)
        tx_sh_reg <= {2'b11, tx_byte, 1'b0};
      else if (par != PAR_NONE)
        tx_sh_reg <= {2'b11, p_bit, tx_byte[6:0], 1'b0};
      else
        tx_sh_reg <= {3'b111, tx_byte[6:0], 1'b0};
      tx_left_reg <= nbits;
      tx_cnt_reg <= 16'h0000;
    end else if (tx_left_reg != 4'h0) begin
      if (tx_cnt_reg == 16'h0000) begin
        txd <= tx_sh_reg[0];
        tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
        tx_cnt_reg <= div - 16'h0001;
      end else begin
        // Bit counter alone ends the frame; trailing ones in the data must still go out
        tx_cnt_reg <= tx_cnt_reg - 16'h0001;
        if (tx_cnt_reg == 16'h0001)
          tx_left_reg <= tx_left_reg - 4'h1;
      end
    end
  end

  // Receiver samples mid-bit; parity bit is captured but not checked
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_sh_reg <= 10'h000;
      rx_left_reg <= 4'h0;
      rx_cnt_reg <= 16'h0000;
      rx_busy_reg <= 1'b0;
    end else if (!rx_busy_reg) begin
      if (!rxd) begin
        rx_busy_reg <= 1'b1;
        rx_cnt_reg <= {1'b0, div[15:1]};
        rx_left_reg <= nbits;
      end
    end else if (rx_cnt_reg != 16'h0000) begin
      rx_cnt_reg <= rx_cnt_reg - 16'h0001;
    end else begin
      rx_cnt_reg <= div - 16'h0001;
      rx_sh_reg <= {rxd, rx_sh_reg[9:1]};
      rx_left_reg <= rx_left_reg - 4'h1;
      if (rx_left_reg == 4'h1)
        rx_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else if (rx_busy_reg && rx_cnt_reg == 16'h0000 && rx_left_reg == 4'h1) begin
      rx_valid <= 1'b1; // Set wins over a read in the same cycle
      if (nbits == 4'hA && bits8)
        rx_data <= rx_sh_reg[9:2];
      else if (nbits == 4'hA)
        rx_data <= {1'b0, rx_sh_reg[8:2]};
      else
        rx_data <= {1'b0, rx_sh_reg[9:3]};
    end else if (rx_take) begin
      rx_valid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rts <= 1'b0;
      dtr <= 1'b1;
    end else begin
      rts <= ~rx_valid;
      dtr <= 1'b1;
    end
  end
endmodule

module serial_port_waveform_streamer
  import serial_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [2:0] txd,
  input wire logic [2:0] rxd,
  output logic [2:0] rts,
  input wire logic [2:0] cts,
  output logic [2:0] dtr,
  input wire logic power_off,
  input wire logic breath_start,
  input wire logic breath_end,
  input wire logic [9:0] pressure,
  input wire logic [9:0] flow,
  output logic relay_no_closed,
  output logic relay_nc_closed
);
  logic [7:0] cfg_pend_reg [NPORT];
  logic [7:0] cfg_act_reg [NPORT];
  logic [2:0] reject_reg;
  logic [1:0] alarm_reg;
  logic [2:0] tx_rdy, rx_valid, tx_go, rx_take, wave_mask;
  logic [7:0] rx_data [NPORT];
  logic wr, rd, wave_go;
  logic [7:0] wave_char;
  wave_state_t st_reg;
  logic [19:0] buf_mem [2][BUF_LINES];
  logic cap_bank_reg, snd_bank_reg, cap_on_reg;
  logic [8:0] cap_idx_reg, snd_lines_reg, li_reg;
  logic [19:0] smp_cnt_reg;
  logic [9:0] seq_reg, snd_seq_reg;
  logic [3:0] ci_reg;

  function automatic logic cfg_ok(input logic [7:0] c, input int port);
    logic ok;
    ok = c[F_BAUD +: 3] <= BAUD_MAX;
    if (c[F_PAR +: 2] != PAR_NONE && c[F_PAR +: 2] != PAR_EVEN && c[F_PAR +: 2] != PAR_ODD)
      ok = 1'b0;
    if (c[F_BITS8] && c[F_PAR +: 2] != PAR_NONE)
      ok = 1'b0;
    if (port == 0 && c[F_DEV +: 2] == DEV_WAVE)
      ok = 1'b0;
    return ok;
  endfunction

  function automatic logic [7:0] digit(input logic [9:0] v, input int pos);
    int n;
    n = (v > MAX_READING) ? int'(MAX_READING) : int'(v);
    if (pos == 0)
      n = n / 100;
    else if (pos == 1)
      n = (n / 10) % 10;
    else
      n = n % 10;
    return 8'h30 + 8'(n);
  endfunction

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      wave_mask[i] = cfg_act_reg[i][F_DEV +: 2] == DEV_WAVE;
      tx_go[i] = wave_mask[i] ? wave_go
        : (wr && wb_sel_i[0] && wb_adr_i == OFF_TXD0 + PORT_STEP * 8'(i));
      rx_take[i] = rd && wb_adr_i == OFF_RXD0 + PORT_STEP * 8'(i);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : port
      logic [7:0] c;
      assign c = cfg_act_reg[g];
      uart_port uart_port_inst (
        .clock(clock),
        .rst(rst),
        .div(baud_div(c[F_DEV +: 2] == DEV_WAVE ? BAUD_38400 : c[F_BAUD +: 3])),
        .bits8(c[F_BITS8]),
        .par(c[F_PAR +: 2]),
        .tx_go(tx_go[g]),
        .tx_byte(wave_mask[g] ? wave_char : wb_dat_i[7:0]),
        .tx_rdy(tx_rdy[g]),
        .rx_data(rx_data[g]),
        .rx_valid(rx_valid[g]),
        .rx_take(rx_take[g]),
        .txd(txd[g]),
        .rxd(rxd[g]),
        .rts(rts[g]),
        .cts(cts[g]),
        .dtr(dtr[g])
      );
    end
  endgenerate

  // Configuration: pending set is staged, accept copies it if legal
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NPORT; i++) begin
        cfg_pend_reg[i] <= CFG_RESET;
        cfg_act_reg[i] <= CFG_RESET;
      end
      reject_reg <= 3'h0;
    end else begin
      if (wr && wb_sel_i[0] && wb_adr_i == OFF_STAT)
        reject_reg <= reject_reg & ~wb_dat_i[ST_REJ +: 3];
      for (int i = 0; i < NPORT; i++) begin
        if (wr && wb_sel_i[0] && wb_adr_i == OFF_CFG0 + PORT_STEP * 8'(i))
          cfg_pend_reg[i] <= wb_dat_i[7:0];
        if (wr && wb_sel_i[0] && wb_adr_i == OFF_CMD) begin
          if (wb_dat_i[i] && cfg_ok(cfg_pend_reg[i], i))
            cfg_act_reg[i] <= cfg_pend_reg[i];
          else if (wb_dat_i[i])
            reject_reg[i] <= 1'b1;
          else if (wb_dat_i[CMD_CANCEL + i])
            cfg_pend_reg[i] <= cfg_act_reg[i];
        end
      end
    end
  end

  // Alarm relay follows the alarm state or power_off through a single register stage
  always_ff @(posedge clock) begin
    if (rst) begin
      alarm_reg <= 2'h0;
      relay_no_closed <= 1'b0;
      relay_nc_closed <= 1'b1;
    end else begin
      if (wr && wb_sel_i[0] && wb_adr_i == OFF_ALARM)
        alarm_reg <= wb_dat_i[1:0];
      relay_no_closed <= (alarm_reg[AL_ACTIVE] && !alarm_reg[AL_SILENCE]) || power_off;
      relay_nc_closed <= !((alarm_reg[AL_ACTIVE] && !alarm_reg[AL_SILENCE]) || power_off);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (rd) begin
        if (wb_adr_i < OFF_ACT0 && wb_adr_i[1:0] == 2'h0)
          wb_dat_o <= {24'h0, cfg_pend_reg[wb_adr_i[3:2]]};
        else if (wb_adr_i >= OFF_ACT0 && wb_adr_i < OFF_CMD && wb_adr_i[1:0] == 2'h0)
          wb_dat_o <= {24'h0, cfg_act_reg[2'(wb_adr_i[4:2] - 3'h3)]};
        else if (wb_adr_i == OFF_STAT)
          wb_dat_o <= {23'h0, reject_reg, rx_valid, tx_rdy};
        else if (wb_adr_i == OFF_ALARM)
          wb_dat_o <= {30'h0, alarm_reg};
        else if (wb_adr_i >= OFF_RXD0 && wb_adr_i[1:0] == 2'h0 && wb_adr_i < OFF_RXD0 + 8'h0C)
          wb_dat_o <= {24'h0, rx_data[2'(wb_adr_i[3:2])]};
      end
    end
  end

  // Capture: two banks so a new breath fills while the last one drains
  always_ff @(posedge clock) begin
    if (rst) begin
      cap_on_reg <= 1'b0;
      cap_bank_reg <= 1'b0;
      cap_idx_reg <= 9'h000;
      smp_cnt_reg <= 20'h00000;
      seq_reg <= 10'h000;
    end else if (breath_start) begin
      cap_on_reg <= 1'b1;
      cap_bank_reg <= ~cap_bank_reg;
      cap_idx_reg <= 9'h001;
      smp_cnt_reg <= 20'(SAMPLE_CYCLES - 1);
      seq_reg <= (seq_reg == MAX_SEQ) ? 10'h000 : seq_reg + 10'h001;
      buf_mem[~cap_bank_reg][0] <= {flow, pressure};
    end else if (breath_end) begin
      cap_on_reg <= 1'b0;
    end else if (cap_on_reg && smp_cnt_reg == 20'h00000) begin
      smp_cnt_reg <= 20'(SAMPLE_CYCLES - 1);
      if (cap_idx_reg < 9'(BUF_LINES)) begin
        buf_mem[cap_bank_reg][cap_idx_reg] <= {flow, pressure};
        cap_idx_reg <= cap_idx_reg + 9'h001;
      end
    end else if (cap_on_reg) begin
      smp_cnt_reg <= smp_cnt_reg - 20'h00001;
    end
  end

  assign wave_go = (st_reg != ST_IDLE) && ((tx_rdy | ~wave_mask) == 3'h7);

  always_comb begin
    logic [19:0] w;
    w = buf_mem[snd_bank_reg][li_reg];
    wave_char = 8'h0A;
    case (st_reg)
      ST_HDR: begin
        case (ci_reg)
          4'h0: wave_char = 8'h42;
          4'h1: wave_char = 8'h53;
          4'h2: wave_char = 8'h2C;
          4'h3: wave_char = 8'h20;
          4'h4: wave_char = 8'h53;
          4'h5: wave_char = 8'h3A;
          4'h6: wave_char = digit(snd_seq_reg, 0);
          4'h7: wave_char = digit(snd_seq_reg, 1);
          4'h8: wave_char = digit(snd_seq_reg, 2);
          4'h9: wave_char = 8'h2C;
          default: wave_char = 8'h0A;
        endcase
      end
      ST_LINE: begin
        case (ci_reg)
          4'h0: wave_char = digit(w[19:10], 0);
          4'h1: wave_char = digit(w[19:10], 1);
          4'h2: wave_char = digit(w[19:10], 2);
          4'h3: wave_char = 8'h2C;
          4'h4: wave_char = digit(w[9:0], 0);
          4'h5: wave_char = digit(w[9:0], 1);
          4'h6: wave_char = digit(w[9:0], 2);
          default: wave_char = 8'h0A;
        endcase
      end
      ST_END: begin
        case (ci_reg)
          4'h0: wave_char = 8'h42;
          4'h1: wave_char = 8'h45;
          default: wave_char = 8'h0A;
        endcase
      end
      default: wave_char = 8'h0A;
    endcase
  end

  // Sender; a breath ending while the previous record drains is dropped
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= ST_IDLE;
      ci_reg <= 4'h0;
      li_reg <= 9'h000;
      snd_bank_reg <= 1'b0;
      snd_lines_reg <= 9'h000;
      snd_seq_reg <= 10'h000;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (breath_end && cap_on_reg && wave_mask != 3'h0) begin
            st_reg <= ST_HDR;
            snd_bank_reg <= cap_bank_reg;
            snd_lines_reg <= cap_idx_reg;
            snd_seq_reg <= seq_reg;
            ci_reg <= 4'h0;
            li_reg <= 9'h000;
          end
        end
        ST_HDR: begin
          if (wave_go) begin
            ci_reg <= (ci_reg == 4'(HDR_LEN - 1)) ? 4'h0 : ci_reg + 4'h1;
            if (ci_reg == 4'(HDR_LEN - 1))
              st_reg <= ST_LINE;
          end
        end
        ST_LINE: begin
          if (wave_go) begin
            ci_reg <= (ci_reg == 4'(LINE_LEN - 1)) ? 4'h0 : ci_reg + 4'h1;
            if (ci_reg == 4'(LINE_LEN - 1)) begin
              li_reg <= li_reg + 9'h001;
              if (li_reg + 9'h001 >= snd_lines_reg)
                st_reg <= ST_END;
            end
          end
        end
        ST_END: begin
          if (wave_go) begin
            ci_reg <= ci_reg + 4'h1;
            if (ci_reg == 4'(END_LEN - 1))
              st_reg <= ST_IDLE;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

/* tb/serial_chk.sv */
// Assertions on the bus, pins and relay of the serial block
`timescale 1ns/100ps
module serial_chk
  import serial_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [2:0] txd,
  input wire logic [2:0] rxd,
  input wire logic [2:0] rts,
  input wire logic [2:0] cts,
  input wire logic [2:0] dtr,
  input wire logic power_off,
  input wire logic breath_start,
  input wire logic breath_end,
  input wire logic [9:0] pressure,
  input wire logic [9:0] flow,
  input wire logic relay_no_closed,
  input wire logic relay_nc_closed
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic take;
  logic al_wr;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign al_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_ALARM;
  ack_answer_a: assert property (take |=> wb_ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  unmapped_a: assert property (take && !wb_we_i && wb_adr_i > 8'h38 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  dtr_held_a: assert property (dtr == 3'h7)
    else $error("dtr not asserted");
  rts_free_a: assert property (take && !wb_we_i && wb_adr_i == 8'h34 |-> ##[2:3] rts[1])
    else $error("rts not raised after read");
  relay_pair_a: assert property (relay_nc_closed != relay_no_closed)
    else $error("relay contacts not complementary");
  relay_power_a: assert property (power_off |=> relay_no_closed)
    else $error("relay off at power off");
  relay_alarm_a: assert property (al_wr && wb_dat_i[1:0] == 2'h1 ##1 1'b1 |=> relay_no_closed)
    else $error("relay off with alarm");
  relay_mute_a: assert property (al_wr && wb_dat_i[1:0] == 2'h3 ##1 !power_off |=> !relay_no_closed)
    else $error("relay on while silenced");
endmodule

bind serial_port_waveform_streamer serial_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) serial_chk_inst (
  .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .txd(txd), .rxd(rxd), .rts(rts), .cts(cts), .dtr(dtr),
  .power_off(power_off), .breath_start(breath_start), .breath_end(breath_end),
  .pressure(pressure), .flow(flow), .relay_no_closed(relay_no_closed),
  .relay_nc_closed(relay_nc_closed)
);

/* tb/serial_far_end.sv */
// Far-side terminal model: frame decoder and byte sender
`timescale 1ns/100ps
module serial_far_end #(
  parameter int BIT_CYC = 1302,
  parameter int BITS = 8,
  parameter int PAR = 0
)
(
  input wire logic clock,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] rx_q[$];
  int bad = 0;
  logic [7:0] d;
  logic p;
  initial line_out = 1'b1;
  // Mid-bit sampling tolerates the rounded bit time
  always begin
    @(posedge clock iff line_in === 1'b0);
    repeat (BIT_CYC / 2) @(posedge clock);
    d = 8'h00;
    if (line_in !== 1'b0) bad++;
    for (int i = 0; i < BITS; i++) begin
      repeat (BIT_CYC) @(posedge clock);
      d[i] = line_in;
    end
    if (PAR != 0) begin
      repeat (BIT_CYC) @(posedge clock);
      p = line_in;
      if ((^d ^ p) !== (PAR == 2)) bad++;
    end
    repeat (BIT_CYC) @(posedge clock);
    if (line_in !== 1'b1) bad++;
    rx_q.push_back(d);
  end
  // Sends 8N1 only; idle line rests at mark
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      line_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge clock);
    end
  endtask
endmodule

/* tb/serial_port_waveform_streamer_tb.sv */
// Self-checking bench for the serial port block
`timescale 1ns/100ps
module serial_port_waveform_streamer_tb;
  import serial_pkg::*;
  localparam int BIT_CYC = CLK_HZ / 38400;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [2:0] txd, rts, dtr;
  wire [2:0] rxd;
  logic [2:0] cts = 3'h7;
  logic power_off = 1'b0;
  logic breath_start = 1'b0;
  logic breath_end = 1'b0;
  logic [9:0] pressure = 10'h007;
  logic [9:0] flow = 10'h07B;
  logic relay_no_closed, relay_nc_closed;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic [7:0] act;
  logic [7:0] cfg_tab [8] = '{8'h28, 8'h6C, 8'hAC, 8'h80, 8'h54, 8'h18, 8'h03, 8'hC0};
  logic [7:0] rej_mask = 8'hE6;
  // Entry bits: power off, alarm field, expected closing contact
  logic [3:0] al_tab [5] = '{4'h0, 4'h3, 4'h6, 4'hD, 4'h9};
  string hdr = "BS, S:0";
  assign rxd[0] = 1'b1;
  always #10 clock = ~clock;

  serial_port_waveform_streamer #(.SAMPLE_CYCLES(200)) serial_port_waveform_streamer_inst (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .txd(txd), .rxd(rxd), .rts(rts), .cts(cts), .dtr(dtr),
    .power_off(power_off), .breath_start(breath_start), .breath_end(breath_end),
    .pressure(pressure), .flow(flow), .relay_no_closed(relay_no_closed),
    .relay_nc_closed(relay_nc_closed)
  );
  serial_far_end #(.BIT_CYC(BIT_CYC)) near_port1 (
    .clock(clock), .line_in(txd[1]), .line_out(rxd[1])
  );
  serial_far_end #(.BIT_CYC(BIT_CYC), .BITS(7), .PAR(1)) wave_port2 (
    .clock(clock), .line_in(txd[2]), .line_out(rxd[2])
  );
  // Listener only; port 0 receive line stays tied at mark
  serial_far_end #(.BIT_CYC(BIT_CYC), .BITS(7), .PAR(1)) ctl_port0 (
    .clock(clock), .line_in(txd[0]), .line_out()
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    // No wait bound here; only the watchdog ends a stalled access
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Stream of seven characters dominates the run
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    check("dtr", dtr, 3'h7);
    check("rts", rts, 3'h7);
    check("txd idle", txd, 3'h7);
    check("relay", {relay_no_closed, relay_nc_closed}, 2'h1);
    act = CFG_RESET;
    bus(0, OFF_ACT0, 0);
    check("act0", rd, act);
    for (int i = 0; i < 8; i++) begin
      bus(1, OFF_CFG0, cfg_tab[i]);
      bus(1, OFF_CMD, 1);
      bus(0, OFF_STAT, 0);
      check("reject", rd[ST_REJ], rej_mask[i]);
      if (!rej_mask[i]) act = cfg_tab[i];
      bus(0, OFF_ACT0, 0);
      check("act0", rd, act);
      bus(1, OFF_STAT, 32'h1C0);
    end
    bus(1, OFF_CFG0, 8'h2C);
    bus(1, OFF_CMD, 32'h8);
    bus(0, OFF_CFG0, 0);
    check("cancel", rd, act);
    bus(1, 8'h40, 32'hFF);
    bus(0, 8'h40, 0);
    check("unmapped", rd, 0);
    for (int i = 0; i < 5; i++) begin
      bus(1, OFF_ALARM, al_tab[i][2:1]);
      power_off <= al_tab[i][3];
      repeat (3) @(posedge clock);
      check("relay no", relay_no_closed, al_tab[i][0]);
      check("relay nc", relay_nc_closed, !al_tab[i][0]);
    end
    power_off <= 1'b0;
    cts[0] <= 1'b0;
    bus(1, OFF_TXD0, 8'h55);
    repeat (4) @(posedge clock);
    check("txd0 held", txd[0], 1);
    cts[0] <= 1'b1;
    bus(1, OFF_TXD0, 8'h55);
    bus(1, OFF_CFG0 + PORT_STEP, 8'h34);
    bus(1, OFF_CFG0 + 8'h08, 8'h43);
    bus(1, OFF_CMD, 32'h6);
    bus(0, OFF_ACT0 + 8'h08, 0);
    check("act2", rd, 8'h43);
    fork
      begin
        near_port1.send(8'hA5);
        repeat (2) @(posedge clock);
        check("rts1 busy", rts[1], 0);
        bus(0, OFF_STAT, 0);
        check("rx valid", rd[ST_RXV + 1], 1);
        bus(0, OFF_RXD0 + PORT_STEP, 0);
        check("rx byte", rd, 8'hA5);
        repeat (3) @(posedge clock);
        check("rts1 free", rts[1], 1);
      end
      begin
        @(posedge clock);
        breath_start <= 1'b1;
        @(posedge clock);
        breath_start <= 1'b0;
        repeat (450) @(posedge clock);
        breath_end <= 1'b1;
        @(posedge clock);
        breath_end <= 1'b0;
      end
    join
    while (wave_port2.rx_q.size() < 7) @(posedge clock);
    for (int i = 0; i < 7; i++) check("wave char", wave_port2.rx_q[i], hdr[i]);
    check("wave frame", wave_port2.bad, 0);
    check("port0 count", ctl_port0.rx_q.size(), 1);
    check("port0 char", ctl_port0.rx_q[0], 8'h55);
    check("port0 frame", ctl_port0.bad, 0);
    stop_test();
  end
endmodule
